/* inc/uirq_pkg.sv */
/*
  Constants and types shared by the serial port interrupt block: identification
  codes, queue depth, threshold tables, serial timing counts and state codes.
  Assumes a queue depth of sixteen entries on both the transmit and receive side.
*/
`default_nettype none

package uirq_pkg;

  // ----------------------------------------------------------------------
  // Queue geometry
  // ----------------------------------------------------------------------
  localparam int unsigned LEVEL_W    = 5;
  localparam logic [4:0]  QUEUE_FULL = 5'h10;
  localparam logic [4:0]  LEVEL_ZERO = 5'h00;

  // ----------------------------------------------------------------------
  // Identification codes, highest priority first
  // ----------------------------------------------------------------------
  localparam logic [3:0] IID_NONE    = 4'h1;
  localparam logic [3:0] IID_LINE    = 4'h6;
  localparam logic [3:0] IID_RX_DATA = 4'h4;
  localparam logic [3:0] IID_TIMEOUT = 4'hc;
  localparam logic [3:0] IID_TX_EMPTY = 4'h2;
  localparam logic [3:0] IID_RSVD_LO = 4'h0;
  localparam logic [3:0] IID_RSVD_HI = 4'h7;

  // ----------------------------------------------------------------------
  // Transmit empty thresholds, selected by the two-bit threshold field
  // ----------------------------------------------------------------------
  localparam logic [1:0] THR_SEL_EMPTY   = 2'h0;
  localparam logic [1:0] THR_SEL_TWO     = 2'h1;
  localparam logic [1:0] THR_SEL_QUARTER = 2'h2;
  localparam logic [4:0] TX_THR_EMPTY    = 5'h00;
  localparam logic [4:0] TX_THR_TWO      = 5'h02;
  localparam logic [4:0] TX_THR_QUARTER  = 5'h04;
  localparam logic [4:0] TX_THR_HALF     = 5'h08;

  // ----------------------------------------------------------------------
  // Receive trigger levels, selected by the two-bit trigger field
  // ----------------------------------------------------------------------
  localparam logic [1:0] TRIG_SEL_ONE     = 2'h0;
  localparam logic [1:0] TRIG_SEL_QUARTER = 2'h1;
  localparam logic [1:0] TRIG_SEL_HALF    = 2'h2;
  localparam logic [4:0] RX_TRIG_ONE      = 5'h01;
  localparam logic [4:0] RX_TRIG_QUARTER  = 5'h04;
  localparam logic [4:0] RX_TRIG_HALF     = 5'h08;
  localparam logic [4:0] RX_TRIG_NEAR     = 5'h0e;

  // ----------------------------------------------------------------------
  // Serial timing, counted in baud clock ticks
  // ----------------------------------------------------------------------
  localparam int unsigned TICKS_PER_BIT  = 16;
  localparam int unsigned BITS_PER_CHAR  = 10;
  localparam int unsigned TIMEOUT_CHARS  = 4;
  localparam logic [9:0]  TIMEOUT_TICKS  =
    10'(TICKS_PER_BIT * BITS_PER_CHAR * TIMEOUT_CHARS);
  localparam logic [9:0]  TIMEOUT_RESET  = 10'h000;
  localparam logic [3:0]  SETTLE_TICKS   = 4'h8;
  localparam logic [3:0]  SETTLE_RESET   = 4'h0;
  localparam logic [15:0] DIV_RESET      = 16'h0000;
  localparam logic [15:0] DIV_ONE        = 16'h0001;

  // ----------------------------------------------------------------------
  // Serial side settle state
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    UIRQ_SETTLE = 1'b0,
    UIRQ_RUN    = 1'b1
  } uirq_sync_state_t;

endpackage : uirq_pkg

`default_nettype wire

/* rtl/uirq_tick.sv */
/*
  Baud clock enable divider and serial side settle logic. The serial side runs
  on a one-cycle enable derived from the single clock; configuration is taken
  over on that enable. Assumes the divisor is stable except when software
  reconfigures, which is flagged by cfg_change.
*/
`default_nettype none

module uirq_tick (
  input  wire logic        clock,        // System clock.
  input  wire logic        srst,         // Synchronous reset, active high.
  input  wire logic [15:0] divisor,      // Clock cycles per baud tick.
  input  wire logic        cfg_change,   // Pulse: configuration changed.
  input  wire logic        fifo_enable,  // Queues enabled, bus side.
  output logic             baud_tick,    // Pulse: one baud clock.
  output logic             serial_ready, // Serial side has settled.
  output logic             ser_fifo_en   // Queues enabled, serial copy.
);

  logic [15:0]               div_cnt;
  logic [3:0]                settle_cnt;
  uirq_pkg::uirq_sync_state_t state;

  // ----------------------------------------------------------------------
  // Baud divider
  // ----------------------------------------------------------------------

  // Divides the clock down to a one-cycle baud enable.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      div_cnt   <= uirq_pkg::DIV_RESET;
      baud_tick <= 1'b0;
    end
    else if (div_cnt + uirq_pkg::DIV_ONE >= divisor)
    begin
      div_cnt   <= uirq_pkg::DIV_RESET;
      baud_tick <= 1'b1;
    end
    else
    begin
      div_cnt   <= div_cnt + uirq_pkg::DIV_ONE;
      baud_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Settle sequencer
  // ----------------------------------------------------------------------

  // Restarts on a configuration change and runs again after eight baud ticks.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state      <= uirq_pkg::UIRQ_SETTLE;
      settle_cnt <= uirq_pkg::SETTLE_RESET;
    end
    else if (cfg_change)
    begin
      state      <= uirq_pkg::UIRQ_SETTLE;
      settle_cnt <= uirq_pkg::SETTLE_RESET;
    end
    else
    begin
      case (state)
        uirq_pkg::UIRQ_SETTLE:
        begin
          if (baud_tick)
          begin
            settle_cnt <= settle_cnt + 4'h1;
            if (settle_cnt + 4'h1 == uirq_pkg::SETTLE_TICKS)
            begin
              state <= uirq_pkg::UIRQ_RUN;
            end
          end
        end
        uirq_pkg::UIRQ_RUN:
        begin
          settle_cnt <= uirq_pkg::SETTLE_RESET;
        end
        default:
        begin
          state <= uirq_pkg::UIRQ_SETTLE;
        end
      endcase
    end
  end

  // Serial side copy of the queue enable, taken over on the baud enable.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ser_fifo_en  <= 1'b0;
      serial_ready <= 1'b0;
    end
    else
    begin
      serial_ready <= (state == uirq_pkg::UIRQ_RUN) && !cfg_change;
      if (baud_tick)
      begin
        ser_fifo_en <= fifo_enable;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_settle_drop;
    cfg_change |=> !serial_ready;
  endproperty
  a_settle_drop : assert property (p_settle_drop)
    else $error("serial side stayed ready across a configuration change");

endmodule : uirq_tick

`default_nettype wire

/* rtl/uirq_timeout.sv */
/*
  Character timeout detector. Counts baud ticks while the receive queue holds
  data and sees no push and no read. Assumes baud_tick is a one-cycle enable
  at sixteen ticks per serial bit.
*/
`default_nettype none

module uirq_timeout (
  input  wire logic clock,        // System clock.
  input  wire logic srst,         // Synchronous reset, active high.
  input  wire logic baud_tick,    // Pulse: one baud clock.
  input  wire logic run,          // Serial side settled.
  input  wire logic fifo_en,      // Queues enabled, serial copy.
  input  wire logic rx_push,      // Pulse: character entered the queue.
  input  wire logic rbr_read,     // Pulse: receive buffer read.
  input  wire logic rx_nonempty,  // Receive queue holds a character.
  output logic      timeout_pend  // Timeout pending, level.
);

  logic [9:0] idle_cnt;
  logic       quiet;
  logic       expire;

  // Queue is idle: data present, enabled, no traffic this cycle.
  assign quiet  = run && fifo_en && rx_nonempty && !rx_push && !rbr_read;
  assign expire = quiet && baud_tick && (idle_cnt + 10'h001 == uirq_pkg::TIMEOUT_TICKS);

  // Counts four character times of idle queue in baud ticks.
  always_ff @(posedge clock)
  begin
    if (srst || !quiet)
    begin
      idle_cnt <= uirq_pkg::TIMEOUT_RESET;
    end
    else if (baud_tick && !expire)
    begin
      idle_cnt <= idle_cnt + 10'h001;
    end
  end

  // Pending flag: expiry sets it, a receive buffer read clears it.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      timeout_pend <= 1'b0;
    end
    else if (expire)
    begin
      timeout_pend <= 1'b1;
    end
    else if (rbr_read || !fifo_en)
    begin
      timeout_pend <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_to_clear;
    rbr_read |=> !timeout_pend;
  endproperty
  a_to_clear : assert property (p_to_clear)
    else $error("timeout stayed pending after a receive buffer read");

endmodule : uirq_timeout

`default_nettype wire

/* rtl/uirq_top.sv */
/*
  Interrupt generation and prioritisation of a serial port, with the
  programmable transmit empty threshold mode and the serial side settle.
  Assumes the queues, receiver and register decode live outside and report
  their events as one-cycle pulses and their fill levels as counts.
*/
`default_nettype none

module uirq_top (
  input  wire logic        clock,           // System clock, 200 MHz.
  input  wire logic        srst,            // Synchronous reset, active high.
  input  wire logic        ier_rx_err_en,   // Enable line status interrupt.
  input  wire logic        ier_rx_avail_en, // Enable receive data interrupt.
  input  wire logic        ier_timeout_en,  // Enable character timeout interrupt.
  input  wire logic        ier_tx_holding_empty_en,     // Enable transmit empty interrupt.
  input  wire logic        ier_tx_holding_empty_mode,   // Threshold mode select, enable bit 7.
  input  wire logic        fifo_enable,     // Queues enabled, control bit 0.
  input  wire logic [1:0]  tx_threshold,    // Transmit threshold, control bits 5:4.
  input  wire logic [1:0]  rx_trigger,      // Receive trigger, control bits 7:6.
  input  wire logic [15:0] divisor,         // Clock cycles per baud tick.
  input  wire logic        rx_line_err,     // Pulse: overrun, parity, framing, break.
  input  wire logic        lsr_read,        // Pulse: line status register read.
  input  wire logic        rbr_read,        // Pulse: receive buffer read.
  input  wire logic        iir_read,        // Pulse: identification register read.
  input  wire logic        thr_write,       // Pulse: holding register write.
  input  wire logic        rx_push,         // Pulse: character entered receive queue.
  input  wire logic [4:0]  rx_level,        // Receive queue fill, or 0/1 without queue.
  input  wire logic [4:0]  tx_level,        // Transmit queue fill, or 0/1 without queue.
  output logic             irq,             // Interrupt request, active high.
  output logic [3:0]       irq_ident,       // Identification field, bits 3:0.
  output logic             tx_status_bit,   // Line status bit 5.
  output logic             serial_ready     // Serial side settled, traffic allowed.
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [21:0] cfg_now;
  logic [21:0] cfg_q;
  logic        cfg_change;
  logic        baud_tick;
  logic        ser_fifo_en;
  logic        timeout_pend;
  logic        tx_holding_empty_mode_on;
  logic [4:0]  tx_thr;
  logic [4:0]  rx_trig;
  logic        tx_holding_empty_cond;
  logic        tx_holding_empty_cond_q;
  logic        tx_holding_empty_set;
  logic        tx_holding_empty_pend;
  logic        line_pend;
  logic        rx_data_cond;
  logic        line_act;
  logic        rx_data_act;
  logic        timeout_act;
  logic        tx_holding_empty_act;
  logic        any_act;
  logic [3:0]  next_ident;
  logic        next_tx_status;

  // ----------------------------------------------------------------------
  // Configuration tracking and serial side
  // ----------------------------------------------------------------------

  // A change in any serial-relevant setting restarts the serial side.
  assign cfg_now    = {fifo_enable, ier_tx_holding_empty_mode, tx_threshold, rx_trigger, divisor};
  assign cfg_change = (cfg_now != cfg_q);

  // Holds the last seen configuration.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cfg_q <= 22'h000000;
    end
    else
    begin
      cfg_q <= cfg_now;
    end
  end

  uirq_tick u_tick (
    .clock        (clock),
    .srst         (srst),
    .divisor      (divisor),
    .cfg_change   (cfg_change),
    .fifo_enable  (fifo_enable),
    .baud_tick    (baud_tick),
    .serial_ready (serial_ready),
    .ser_fifo_en  (ser_fifo_en)
  );

  uirq_timeout u_timeout (
    .clock        (clock),
    .srst         (srst),
    .baud_tick    (baud_tick),
    .run          (serial_ready),
    .fifo_en      (ser_fifo_en),
    .rx_push      (rx_push),
    .rbr_read     (rbr_read),
    .rx_nonempty  (rx_level != uirq_pkg::LEVEL_ZERO),
    .timeout_pend (timeout_pend)
  );

  // ----------------------------------------------------------------------
  // Threshold mode and level decode
  // ----------------------------------------------------------------------

  // Threshold mode needs both the select bit and enabled queues.
  assign tx_holding_empty_mode_on = ier_tx_holding_empty_mode && fifo_enable;

  // Threshold and trigger tables.
  always_comb
  begin
    case (tx_threshold)
      uirq_pkg::THR_SEL_EMPTY:   tx_thr = uirq_pkg::TX_THR_EMPTY;
      uirq_pkg::THR_SEL_TWO:     tx_thr = uirq_pkg::TX_THR_TWO;
      uirq_pkg::THR_SEL_QUARTER: tx_thr = uirq_pkg::TX_THR_QUARTER;
      default:                   tx_thr = uirq_pkg::TX_THR_HALF;
    endcase
    case (rx_trigger)
      uirq_pkg::TRIG_SEL_ONE:     rx_trig = uirq_pkg::RX_TRIG_ONE;
      uirq_pkg::TRIG_SEL_QUARTER: rx_trig = uirq_pkg::RX_TRIG_QUARTER;
      uirq_pkg::TRIG_SEL_HALF:    rx_trig = uirq_pkg::RX_TRIG_HALF;
      default:                    rx_trig = uirq_pkg::RX_TRIG_NEAR;
    endcase
  end

  // Transmit empty condition and status bit 5 in either mode.
  assign tx_holding_empty_cond = tx_holding_empty_mode_on ? (tx_level <= tx_thr)
                                  : (tx_level == uirq_pkg::LEVEL_ZERO);
  assign next_tx_status = tx_holding_empty_mode_on ? (tx_level == uirq_pkg::QUEUE_FULL)
                                       : (tx_level == uirq_pkg::LEVEL_ZERO);
  assign tx_holding_empty_set = tx_holding_empty_cond && !tx_holding_empty_cond_q;

  // Receive data: any character without queues, trigger level with them.
  assign rx_data_cond = fifo_enable ? (rx_level >= rx_trig)
                                    : (rx_level != uirq_pkg::LEVEL_ZERO);

  // ----------------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------------

  // Line status: an error sets it, a status read clears it; set wins.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      line_pend <= 1'b0;
    end
    else if (rx_line_err)
    begin
      line_pend <= 1'b1;
    end
    else if (lsr_read)
    begin
      line_pend <= 1'b0;
    end
  end

  // Transmit empty: rises on entering the condition; cleared by an
  // identification read while reported, a write outside threshold mode, or leaving the condition.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      tx_holding_empty_cond_q <= 1'b0;
      tx_holding_empty_pend   <= 1'b0;
    end
    else
    begin
      tx_holding_empty_cond_q <= tx_holding_empty_cond;
      if (tx_holding_empty_set)
      begin
        tx_holding_empty_pend <= 1'b1;
      end
      else if (!tx_holding_empty_cond || (thr_write && !tx_holding_empty_mode_on) ||
               (iir_read && irq_ident == uirq_pkg::IID_TX_EMPTY))
      begin
        tx_holding_empty_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Priority and outputs
  // ----------------------------------------------------------------------

  // Enabled and active sources.
  assign line_act    = line_pend && ier_rx_err_en;
  assign rx_data_act = rx_data_cond && ier_rx_avail_en;
  assign timeout_act = timeout_pend && ier_timeout_en && fifo_enable;
  assign tx_holding_empty_act    = tx_holding_empty_pend && ier_tx_holding_empty_en;
  assign any_act     = line_act || rx_data_act || timeout_act || tx_holding_empty_act;

  // Highest pending source wins; reserved codes are never produced.
  always_comb
  begin
    if (line_act)
    begin
      next_ident = uirq_pkg::IID_LINE;
    end
    else if (rx_data_act)
    begin
      next_ident = uirq_pkg::IID_RX_DATA;
    end
    else if (timeout_act)
    begin
      next_ident = uirq_pkg::IID_TIMEOUT;
    end
    else if (tx_holding_empty_act)
    begin
      next_ident = uirq_pkg::IID_TX_EMPTY;
    end
    else
    begin
      next_ident = uirq_pkg::IID_NONE;
    end
  end

  // Registered outputs.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irq           <= 1'b0;
      irq_ident     <= uirq_pkg::IID_NONE;
      tx_status_bit <= 1'b1;
    end
    else
    begin
      irq           <= any_act;
      irq_ident     <= next_ident;
      tx_status_bit <= next_tx_status;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_line_served;
    irq_ident == uirq_pkg::IID_LINE && lsr_read && !rx_line_err;
  endsequence

  sequence s_tx_holding_empty_served;
    irq_ident == uirq_pkg::IID_TX_EMPTY && iir_read && !tx_holding_empty_set;
  endsequence

  property p_irq_follows;
    any_act |=> irq;
  endproperty
  a_irq_follows : assert property (p_irq_follows)
    else $error("interrupt not raised for an active source");

  property p_ident_none;
    !any_act |=> irq_ident == uirq_pkg::IID_NONE && !irq;
  endproperty
  a_ident_none : assert property (p_ident_none)
    else $error("idle identification is not the none code");

  property p_line_first;
    line_act |=> irq_ident == uirq_pkg::IID_LINE;
  endproperty
  a_line_first : assert property (p_line_first)
    else $error("line status not reported first");

  property p_next_source;
    s_line_served ##0 (rx_data_act && $stable(rx_level)) |-> ##2
      (irq_ident == uirq_pkg::IID_RX_DATA || $past(rx_line_err) || !ier_rx_avail_en);
  endproperty
  a_next_source : assert property (p_next_source)
    else $error("next source not reported after line status cleared");

  property p_rx_data_prio;
    rx_data_act && !line_act |=> irq_ident == uirq_pkg::IID_RX_DATA;
  endproperty
  a_rx_data_prio : assert property (p_rx_data_prio)
    else $error("receive data not reported at second priority");

  property p_tx_holding_empty_iir_clear;
    s_tx_holding_empty_served |=> !tx_holding_empty_pend;
  endproperty
  a_tx_holding_empty_iir_clear : assert property (p_tx_holding_empty_iir_clear)
    else $error("transmit empty still pending after identification read");

  property p_full_status;
    tx_holding_empty_mode_on && tx_level == uirq_pkg::QUEUE_FULL |=> tx_status_bit;
  endproperty
  a_full_status : assert property (p_full_status)
    else $error("status bit 5 not showing full in threshold mode");

  property p_mode_off;
    !fifo_enable && tx_level != uirq_pkg::LEVEL_ZERO |=> !tx_status_bit;
  endproperty
  a_mode_off : assert property (p_mode_off)
    else $error("status bit 5 set with data held and queues disabled");

  property p_no_reserved;
    irq_ident != uirq_pkg::IID_RSVD_LO && irq_ident != uirq_pkg::IID_RSVD_HI;
  endproperty
  a_no_reserved : assert property (p_no_reserved)
    else $error("reserved identification code reported");

  property p_timeout_gate;
    !fifo_enable |=> irq_ident != uirq_pkg::IID_TIMEOUT;
  endproperty
  a_timeout_gate : assert property (p_timeout_gate)
    else $error("timeout reported with queues disabled");

endmodule : uirq_top

`default_nettype wire

/* verif/uirq_host.sv */
/*
  Host model: reads the identification code when a transmit empty request is up.
  Assumes the bench enables it only while servicing.
*/
`default_nettype none

module uirq_host (
  input  wire logic       clock,     // System clock.
  input  wire logic       svc_en,    // Servicing allowed.
  input  wire logic       irq,       // Interrupt request.
  input  wire logic [3:0] irq_ident, // Identification code.
  output logic            iir_read   // Pulse: identification read.
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-cycle reads with a gap, so the cleared code can settle.
  initial iir_read = 1'b0;
  always @(posedge clock)
  begin
    iir_read <= #1 svc_en && irq && !iir_read && (irq_ident === uirq_pkg::IID_TX_EMPTY);
  end
endmodule : uirq_host

`default_nettype wire

/* verif/test_uirq_top.sv */
/*
  Self-checking bench for the interrupt block. Assumes the host model answers
  transmit empty requests while svc is high.
*/
`default_nettype none

module test_uirq_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, srst, svc, irq, rdy, tsb, iir_read;
  logic en_le, en_rx, en_to, en_te, mode, fen, le, lsr_rd, rbr_rd, thr_wr, push;
  logic [1:0] thr_sel, trig;
  logic [4:0] rx_level, tx_level, th;
  logic [3:0] id;
  int fail_count, total_checks, cyc;
  // ----------------------------------------------------------------------
  // Instances and clock
  // ----------------------------------------------------------------------
  uirq_top i_uirq_top (.clock(clock), .srst(srst), .ier_rx_err_en(en_le),
    .ier_rx_avail_en(en_rx), .ier_timeout_en(en_to), .ier_tx_holding_empty_en(en_te),
    .ier_tx_holding_empty_mode(mode), .fifo_enable(fen), .tx_threshold(thr_sel), .rx_trigger(trig),
    .divisor(16'h0001), .rx_line_err(le), .lsr_read(lsr_rd), .rbr_read(rbr_rd),
    .iir_read(iir_read), .thr_write(thr_wr), .rx_push(push), .rx_level(rx_level),
    .tx_level(tx_level), .irq(irq), .irq_ident(id), .tx_status_bit(tsb),
    .serial_ready(rdy));
  uirq_host i_uirq_host (.clock(clock), .svc_en(svc), .irq(irq), .irq_ident(id),
    .iir_read(iir_read));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Cuts a hang short.
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Waits a bounded time for the serial side to settle.
  task automatic wait_rdy();
    tick(1);
    for (int i = 0; i < 12 && rdy !== 1'b1; i++) tick(1);
    chk({3'h0, rdy}, 4'h1);
  endtask : wait_rdy
  task automatic finish_test();
    $display("checks=%0d errors=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {svc, le, lsr_rd, rbr_rd, thr_wr, push, mode} = '0;
    {en_le, en_rx, en_to, en_te, fen, srst} = '1;
    {thr_sel, trig, rx_level, tx_level} = {2'h0, 2'h1, 5'h00, 5'h01};
    tick(4);
    srst = 1'b0;
    chk(id, 4'h1);
    wait_rdy();
    chk({3'h0, tsb}, 4'h0);
    // Line error and receive data together, then cleared in turn.
    {le, rx_level} = {1'b1, 5'h04};
    tick(1);
    le = 1'b0;
    tick(1);
    chk(id, 4'h6);
    chk({3'h0, irq}, 4'h1);
    lsr_rd = 1'b1;
    tick(1);
    lsr_rd = 1'b0;
    tick(2);
    chk(id, 4'h4);
    rx_level = 5'h03;
    tick(2);
    chk(id, 4'h1);
    // A push part way restarts the idle count from zero.
    tick(300);
    push = 1'b1;
    tick(1);
    push = 1'b0;
    tick(590);
    chk(id, 4'h1);
    tick(60);
    chk(id, 4'hc);
    {rbr_rd, rx_level} = {1'b1, 5'h00};
    tick(1);
    rbr_rd = 1'b0;
    tick(2);
    chk(id, 4'h1);
    // Transmit empty cleared by an identification read, then by a write.
    tx_level = 5'h00;
    tick(2);
    chk(id, 4'h2);
    chk({3'h0, tsb}, 4'h1);
    svc = 1'b1;
    tick(4);
    svc = 1'b0;
    chk(id, 4'h1);
    tx_level = 5'h01;
    tick(2);
    tx_level = 5'h00;
    tick(3);
    chk(id, 4'h2);
    thr_wr = 1'b1;
    tick(1);
    thr_wr = 1'b0;
    tick(2);
    chk(id, 4'h1);
    // Threshold mode over every threshold code.
    {mode, tx_level} = {1'b1, 5'h10};
    wait_rdy();
    tick(2);
    chk({3'h0, tsb}, 4'h1);
    for (int k = 0; k < 4; k++)
    begin
      thr_sel = 2'(k);
      th = (k == 0) ? 5'h00 : 5'(2 << (k - 1));
      wait_rdy();
      tx_level = th + 5'h01;
      tick(3);
      chk(id, 4'h1);
      tx_level = th;
      tick(3);
      chk(id, 4'h2);
      tx_level = th + 5'h01;
      tick(3);
      chk(id, 4'h1);
    end
    // Filling after a threshold request: status bit 5 shows full only at sixteen.
    for (int n = 9; n <= 16; n++)
    begin
      tx_level = 5'(n);
      tick(2);
      chk({3'h0, tsb}, {3'h0, n == 16});
    end
    // Queues off turn the threshold mode off.
    {fen, tx_level} = {1'b0, 5'h00};
    wait_rdy();
    tick(2);
    chk({3'h0, tsb}, 4'h1);
    // Without queues any held character raises receive data above transmit empty.
    rx_level = 5'h01;
    tick(2);
    chk(id, 4'h4);
    finish_test();
  end
endmodule : test_uirq_top

`default_nettype wire
